// *** nfc_cmd_top.sv ***
// Behaviour
// RULE_01 - Accept-all-multicast command bypasses group filtering, reports 00.
// RULE_02 - Clear command returns to hashed, byte-compared group table filtering.
// RULE_03 - Power-up, reset and diagnostics commands restore table-filtered multicast mode.
// RULE_04 - Group recognition table holds 63 multicast entries.
// RULE_05 - Multicast mode applies to network and internally looped-back packets alike.
// RULE_06 - Loopback test sends two minimum frames, fixed address, first with bad CRC.
// RULE_07 - Loopback checks CRC outcome and last byte; codes 0C, 0D, 0E.
// RULE_08 - Loopback codes: 00, 01 retries, 03 offline, 04 jabber, 08 excess.
// RULE_09 - Collision test sends one frame, expects heartbeat near 1 us; 00 or 0B.
// RULE_10 - Host never writes reserved codes 14h to 17h.
// RULE_11 - Statistics command drives block-pending low, interrupting if enabled.
// RULE_12 - Byte-waiting flag is set while status register holds next byte.
// RULE_13 - Host reads status byte, then flags, until block-pending returns high.
// RULE_14 - After the report all counters clear except receive-FIFO frame count.
// RULE_15 - Counters zero at power-up, reset command and board reset.
// RULE_16 - Block: two-byte length 62 low first, address, counters low byte first.
// RULE_17 - Received count includes filtered multicast; runt, lost, multicast counters.
// RULE_18 - Excess-collision count per 16-collision frame; separate total collision count.
// RULE_19 - CRC-error and alignment-error frames are counted separately.
// RULE_20 - Late collisions after the first slot time have their own counter.
// RULE_21 - Reserved area reads zero, then null-terminated module and firmware identifiers.
// RULE_22 - Host drains the whole status block before reading receive data.
// RULE_23 - Host writes one-byte command codes to the command register.
// RULE_24 - Each 16-bit counter wraps to zero on overflow.
`default_nettype none
module nfc_cmd_top #(
	parameter logic [63:0] MODULE_ID = 64'h4D4F44554C450000, // Arbitrary value.
	parameter logic [63:0] FW_ID     = 64'h4657303030310000, // Arbitrary value.
	parameter int          FIFO_D    = 8
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	output logic             o_cmd_busy,
	output logic             o_cmd_done,
	output logic [7:0]       o_cmd_status,
	input  wire logic        i_stat_rd,
	output logic [7:0]       o_stat_byte,
	output logic             o_status_byte_waiting,
	output logic             o_status_block_pending_n,
	input  wire logic        i_sba_int_en,
	input  wire logic        i_srf_int_en,
	output logic             o_host_int,
	input  wire logic [47:0] i_phys_addr,
	input  wire logic        i_online,
	output logic             o_tx_start,
	output logic             o_tx_bad_crc,
	output logic [47:0]      o_tx_addr,
	input  wire logic        i_tx_done,
	input  wire logic        i_tx_collided,
	input  wire logic        i_tx_jabber,
	input  wire logic        i_tx_excess,
	input  wire logic        i_rx_done,
	input  wire logic        i_rx_crc_ok,
	input  wire logic        i_rx_data_ok,
	input  wire logic        i_heartbeat,
	output logic             o_accept_all_mc,
	input  wire logic        i_grp_wr,
	input  wire logic [5:0]  i_grp_idx,
	input  wire logic [47:0] i_grp_addr,
	input  wire logic        i_mc_check,
	input  wire logic [47:0] i_mc_dest,
	output logic             o_mc_busy,
	output logic             o_mc_done,
	output logic             o_mc_accept,
	input  wire logic [15:0] i_rx_fifo_frames,
	input  wire logic        i_ev_rx_frame,
	input  wire logic        i_ev_tx_frame,
	input  wire logic        i_ev_excess,
	input  wire logic        i_ev_runt,
	input  wire logic        i_ev_lost,
	input  wire logic        i_ev_mc_acc,
	input  wire logic        i_ev_mc_rej,
	input  wire logic        i_ev_crc_err,
	input  wire logic        i_ev_align_err,
	input  wire logic        i_ev_coll,
	input  wire logic        i_ev_late_coll
);
	import nfc_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_q, rst_n_q;

	// Assertion is immediate; release is delayed by two edges.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Statistics counters
	// ----------------------------------------------------------------
	logic               clr_d, clr_q;
	logic [NUM_CTR-1:0] ev;
	logic [15:0]        ctr_v  [NUM_CTR];
	logic [15:0]        word_v [NUM_WORDS];

	// Order matches the block layout, receive-FIFO count excluded.
	assign ev = {i_ev_late_coll, i_ev_coll, i_ev_align_err, i_ev_crc_err, // RULE_19 RULE_20
	             i_ev_mc_rej, i_ev_mc_acc, i_ev_lost, i_ev_runt,           // RULE_17
	             i_ev_excess, i_ev_tx_frame, i_ev_rx_frame};               // RULE_18

	generate
		for (genvar k = 0; k < NUM_CTR; k++) begin : g_ctr
			nfc_stat_ctr #(.W(16)) u_ctr (
				.i_clk_sys (i_clk_sys),
				.i_rst_n   (rst_n_q),
				.i_inc     (ev[k]),
				.i_clr     (clr_q), // RULE_14 RULE_15
				.o_count   (ctr_v[k])
			);
		end
	endgenerate

	// The receive-FIFO frame count is live and never cleared here.
	always_comb begin
		word_v[0] = ctr_v[0];
		word_v[1] = i_rx_fifo_frames; // RULE_14
		for (int k = 1; k < NUM_CTR; k++) begin
			word_v[k+1] = ctr_v[k];
		end
	end

	// ----------------------------------------------------------------
	// Status block byte generator
	// ----------------------------------------------------------------
	logic [6:0] idx_q, idx_d;
	logic [7:0] blk_byte;
	logic [3:0] wsel;
	logic [2:0] isel;

	assign wsel = 4'((idx_q - OFS_CTR) >> 1);
	assign isel = 3'(idx_q);

	// Counters go out live, so an event landing mid-report may be lost at the clear.
	always_comb begin
		if (idx_q < OFS_PHYS) begin
			blk_byte = idx_q[0] ? BLK_LEN[15:8] : BLK_LEN[7:0]; // RULE_16
		end else if (idx_q < OFS_CTR) begin
			blk_byte = i_phys_addr[8'(47 - 8 * (idx_q - OFS_PHYS)) -: 8];
		end else if (idx_q < OFS_RSVD) begin
			blk_byte = idx_q[0] ? word_v[wsel][15:8] : word_v[wsel][7:0]; // RULE_16
		end else if (idx_q < OFS_MOD) begin
			blk_byte = 8'h00; // RULE_21
		end else if (idx_q < OFS_FW) begin
			blk_byte = MODULE_ID[8'(63 - 8 * isel) -: 8]; // RULE_21
		end else begin
			blk_byte = FW_ID[8'(63 - 8 * isel) -: 8];
		end
	end

	// ----------------------------------------------------------------
	// Status byte FIFO and status register
	// ----------------------------------------------------------------
	nfc_state_t state_q, state_d;
	logic       fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [7:0] fifo_out_data;
	logic       full_q, full_d;
	logic [7:0] sbyte_q, sbyte_d;

	// The status register stalls the FIFO, which stalls the generator.
	nfc_fifo #(.W(8), .D(FIFO_D)) u_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_rst_n     (rst_n_q),
		.i_in_valid  (state_q == NFC_ST_GEN),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (blk_byte),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out_data)
	);

	assign fifo_pop = fifo_out_valid && (!full_q || i_stat_rd);

	always_comb begin
		full_d  = full_q;
		sbyte_d = sbyte_q;
		if (fifo_pop) begin
			full_d  = 1'b1; // RULE_12
			sbyte_d = fifo_out_data;
		end else if (i_stat_rd) begin
			full_d = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	logic [7:0] status_d, status_q;
	logic       done_d, done_q, txs_d, txs_q, bad_d, bad_q, coll_d, coll_q;
	logic       allmc_d, allmc_q, grp_clr;
	logic [7:0] hb_d, hb_q;

	// Reserved and unhandled codes give no done and only set the status to 00; commands given while busy are dropped.
	always_comb begin
		state_d  = state_q;
		status_d = status_q;
		done_d   = 1'b0;
		txs_d    = 1'b0;
		bad_d    = bad_q;
		coll_d   = coll_q;
		allmc_d  = allmc_q;
		hb_d     = hb_q;
		idx_d    = idx_q;
		clr_d    = 1'b0;
		grp_clr  = 1'b0;
		case (state_q)
			NFC_IDLE: begin
				if (i_cmd_valid) begin
					done_d   = 1'b1;
					status_d = ST_OK;
					case (i_cmd_code)
						CMD_SET_ALLMC: allmc_d = 1'b1; // RULE_01
						CMD_CLR_ALLMC: allmc_d = 1'b0; // RULE_02
						CMD_DIAG:      allmc_d = RST_ALLMC; // RULE_03
						CMD_RESET: begin
							allmc_d = RST_ALLMC; // RULE_03
							clr_d   = 1'b1; // RULE_15
							grp_clr = 1'b1;
						end
						CMD_LOOPBACK: begin
							if (!i_online) begin
								status_d = ST_INAPPROP; // RULE_08
							end else begin
								done_d  = 1'b0;
								txs_d   = 1'b1;
								bad_d   = 1'b1; // RULE_06
								coll_d  = 1'b0;
								state_d = NFC_LB_TX1;
							end
						end
						CMD_HEARTBEAT: begin
							done_d  = 1'b0;
							txs_d   = 1'b1; // RULE_09
							bad_d   = 1'b0;
							state_d = NFC_HB_TX;
						end
						CMD_STATS: begin
							done_d  = 1'b0;
							idx_d   = '0;
							state_d = NFC_ST_GEN; // RULE_11
						end
						default: done_d = 1'b0;
					endcase
				end
			end
			NFC_LB_TX1, NFC_LB_TX2: begin
				if (i_tx_done) begin
					coll_d = coll_q | i_tx_collided;
					if (i_tx_jabber) begin
						done_d   = 1'b1;
						status_d = ST_JABBER; // RULE_08
						state_d  = NFC_IDLE;
					end else if (i_tx_excess) begin
						done_d   = 1'b1;
						status_d = ST_EXCESS; // RULE_08
						state_d  = NFC_IDLE;
					end else begin
						state_d = (state_q == NFC_LB_TX1) ? NFC_LB_RX1 : NFC_LB_RX2;
					end
				end
			end
			NFC_LB_RX1: begin
				if (i_rx_done) begin
					if (i_rx_crc_ok || !i_rx_data_ok) begin
						done_d   = 1'b1;
						status_d = i_rx_crc_ok ? ST_BAD_PASSED : ST_DATA_ERR; // RULE_07
						state_d  = NFC_IDLE;
					end else begin
						txs_d   = 1'b1;
						bad_d   = 1'b0; // RULE_06
						state_d = NFC_LB_TX2;
					end
				end
			end
			NFC_LB_RX2: begin
				if (i_rx_done) begin
					done_d  = 1'b1;
					state_d = NFC_IDLE;
					if (!i_rx_crc_ok) begin
						status_d = ST_GOOD_FAIL; // RULE_07
					end else if (!i_rx_data_ok) begin
						status_d = ST_DATA_ERR;
					end else begin
						status_d = coll_q ? ST_RETRIES : ST_OK; // RULE_08
					end
				end
			end
			NFC_HB_TX: begin
				if (i_tx_done) begin
					hb_d    = '0;
					state_d = NFC_HB_WAIT;
				end
			end
			NFC_HB_WAIT: begin
				if (i_heartbeat || hb_q == HB_WIN_CYC - 8'h01) begin
					done_d   = 1'b1;
					status_d = i_heartbeat ? ST_OK : ST_NO_HBEAT; // RULE_09
					state_d  = NFC_IDLE;
				end else begin
					hb_d = hb_q + 8'h01;
				end
			end
			NFC_ST_GEN: begin
				if (fifo_in_ready) begin
					idx_d = idx_q + 7'h01;
					if (idx_q == BLK_BYTES - 7'h01) begin
						state_d = NFC_ST_DRAIN;
					end
				end
			end
			NFC_ST_DRAIN: begin
				if (!fifo_out_valid && !full_q) begin
					clr_d    = 1'b1; // RULE_14
					done_d   = 1'b1;
					status_d = ST_OK;
					state_d  = NFC_IDLE;
				end
			end
			default: state_d = NFC_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Group address table and multicast filter
	// ----------------------------------------------------------------
	logic [47:0] grp_tab [GRP_ENTRIES];
	logic [62:0] grp_vld_q, grp_vld_d;
	logic [5:0]  ptr_q, ptr_d, left_q, left_d, hash;
	logic        mbusy_q, mbusy_d, mdone_d, mdone_q, macc_d, macc_q;
	logic [47:0] mdest_q, mdest_d;
	logic [7:0]  fold;

	// Byte fold of the destination picks where the table scan starts.
	assign fold = i_mc_dest[47:40] ^ i_mc_dest[39:32] ^ i_mc_dest[31:24] ^
	              i_mc_dest[23:16] ^ i_mc_dest[15:8] ^ i_mc_dest[7:0];
	assign hash = (fold[5:0] == 6'h3F) ? 6'h00 : fold[5:0]; // RULE_02

	// The filter ignores the packet's origin, so loopback is filtered alike.
	always_comb begin
		grp_vld_d = grp_vld_q;
		ptr_d     = ptr_q;
		left_d    = left_q;
		mbusy_d   = mbusy_q;
		mdone_d   = 1'b0;
		macc_d    = macc_q;
		mdest_d   = mdest_q;
		if (grp_clr) begin
			grp_vld_d = '0;
		end else if (i_grp_wr && i_grp_idx != 6'h3F) begin
			grp_vld_d[i_grp_idx] = 1'b1; // RULE_04
		end
		if (!mbusy_q && i_mc_check) begin
			if (allmc_q) begin
				mdone_d = 1'b1;
				macc_d  = 1'b1; // RULE_01 RULE_05
			end else begin
				mbusy_d = 1'b1;
				ptr_d   = hash;
				left_d  = 6'(GRP_ENTRIES - 1);
				mdest_d = i_mc_dest;
			end
		end else if (mbusy_q) begin
			if (grp_vld_q[ptr_q] && grp_tab[ptr_q] == mdest_q) begin
				mbusy_d = 1'b0;
				mdone_d = 1'b1;
				macc_d  = 1'b1; // RULE_02
			end else if (left_q == 6'h00) begin
				mbusy_d = 1'b0;
				mdone_d = 1'b1;
				macc_d  = 1'b0;
			end else begin
				left_d = left_q - 6'h01;
				ptr_d  = (ptr_q == 6'(GRP_ENTRIES - 1)) ? 6'h00 : ptr_q + 6'h01;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_grp_wr && i_grp_idx != 6'h3F) begin
			grp_tab[i_grp_idx] <= i_grp_addr;
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q   <= NFC_IDLE;
			status_q  <= ST_OK;
			done_q    <= 1'b0;
			txs_q     <= 1'b0;
			bad_q     <= 1'b0;
			coll_q    <= 1'b0;
			allmc_q   <= RST_ALLMC; // RULE_03
			hb_q      <= '0;
			idx_q     <= '0;
			clr_q     <= 1'b0;
			full_q    <= 1'b0;
			sbyte_q   <= '0;
			grp_vld_q <= '0;
			ptr_q     <= '0;
			left_q    <= '0;
			mbusy_q   <= 1'b0;
			mdone_q   <= 1'b0;
			macc_q    <= 1'b0;
			mdest_q   <= '0;
			o_cmd_busy               <= 1'b0;
			o_status_block_pending_n <= 1'b1;
			o_host_int               <= 1'b0;
			o_tx_addr                <= TEST_ADDR;
		end else begin
			state_q   <= state_d;
			status_q  <= status_d;
			done_q    <= done_d;
			txs_q     <= txs_d;
			bad_q     <= bad_d;
			coll_q    <= coll_d;
			allmc_q   <= allmc_d;
			hb_q      <= hb_d;
			idx_q     <= idx_d;
			clr_q     <= clr_d;
			full_q    <= full_d;
			sbyte_q   <= sbyte_d;
			grp_vld_q <= grp_vld_d;
			ptr_q     <= ptr_d;
			left_q    <= left_d;
			mbusy_q   <= mbusy_d;
			mdone_q   <= mdone_d;
			macc_q    <= macc_d;
			mdest_q   <= mdest_d;
			o_cmd_busy               <= (state_d != NFC_IDLE);
			o_status_block_pending_n <= !(state_d == NFC_ST_GEN || state_d == NFC_ST_DRAIN); // RULE_11
			o_host_int               <= (i_sba_int_en && (state_d == NFC_ST_GEN || state_d == NFC_ST_DRAIN)) ||
			                            (i_srf_int_en && full_d); // RULE_11 RULE_12
			o_tx_addr                <= TEST_ADDR; // RULE_06
		end
	end

	// Remaining outputs are the registers themselves.
	assign o_cmd_done            = done_q;
	assign o_cmd_status          = status_q;
	assign o_stat_byte           = sbyte_q;
	assign o_status_byte_waiting = full_q;
	assign o_tx_start            = txs_q;
	assign o_tx_bad_crc          = bad_q;
	assign o_accept_all_mc       = allmc_q;
	assign o_mc_busy             = mbusy_q;
	assign o_mc_done             = mdone_q;
	assign o_mc_accept           = macc_q;
endmodule : nfc_cmd_top
`default_nettype wire

// *** nfc_pkg.sv ***
`default_nettype none
package nfc_pkg;
	// ----------------------------------------------------------------
	// Command codes and status codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_DIAG      = 8'h0A;
	localparam logic [7:0] CMD_SET_ALLMC = 8'h10;
	localparam logic [7:0] CMD_CLR_ALLMC = 8'h11;
	localparam logic [7:0] CMD_LOOPBACK  = 8'h12;
	localparam logic [7:0] CMD_HEARTBEAT = 8'h13;
	localparam logic [7:0] CMD_STATS     = 8'h18;
	localparam logic [7:0] CMD_RESET     = 8'h3F;
	localparam logic [7:0] ST_OK         = 8'h00;
	localparam logic [7:0] ST_RETRIES    = 8'h01;
	localparam logic [7:0] ST_INAPPROP   = 8'h03;
	localparam logic [7:0] ST_JABBER     = 8'h04;
	localparam logic [7:0] ST_EXCESS     = 8'h08;
	localparam logic [7:0] ST_NO_HBEAT   = 8'h0B;
	localparam logic [7:0] ST_BAD_PASSED = 8'h0C;
	localparam logic [7:0] ST_DATA_ERR   = 8'h0D;
	localparam logic [7:0] ST_GOOD_FAIL  = 8'h0E;
	// ----------------------------------------------------------------
	// Statistics block layout (byte offsets inside the block)
	// ----------------------------------------------------------------
	localparam logic [15:0] BLK_LEN      = 16'h003E;
	localparam logic [6:0]  BLK_BYTES    = 7'h40;
	localparam logic [6:0]  OFS_PHYS     = 7'h02;
	localparam logic [6:0]  OFS_CTR      = 7'h08;
	localparam logic [6:0]  OFS_RSVD     = 7'h20;
	localparam logic [6:0]  OFS_MOD      = 7'h30;
	localparam logic [6:0]  OFS_FW       = 7'h38;
	localparam int          NUM_CTR      = 11;
	localparam int          NUM_WORDS    = 12;
	// ----------------------------------------------------------------
	// Self-test constants and timing
	// ----------------------------------------------------------------
	localparam logic [47:0] TEST_ADDR    = 48'h020701000000;
	localparam int          GRP_ENTRIES  = 63;
	localparam int          CLK_NS       = 25;
	localparam int          HB_NOM_NS    = 1000;
	localparam int          HB_WIN_NS    = 2 * HB_NOM_NS;
	localparam logic [7:0]  HB_WIN_CYC   = 8'(HB_WIN_NS / CLK_NS);
	localparam logic        RST_ALLMC    = 1'b0;
	typedef enum logic [3:0] {
		NFC_IDLE, NFC_LB_TX1, NFC_LB_RX1, NFC_LB_TX2, NFC_LB_RX2,
		NFC_HB_TX, NFC_HB_WAIT, NFC_ST_GEN, NFC_ST_DRAIN
	} nfc_state_t;
endpackage : nfc_pkg
`default_nettype wire

// *** nfc_stat_ctr.sv ***
`default_nettype none
module nfc_stat_ctr #(
	parameter int W = 16
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_n,
	input  wire logic         i_inc,
	input  wire logic         i_clr,
	output logic [W-1:0]      o_count
);
	logic [W-1:0] cnt_d;
	logic [W-1:0] cnt_q;

	// An event in the clearing cycle is kept as a count of one.
	always_comb begin
		if (i_clr) begin
			cnt_d = i_inc ? W'(1) : '0;
		end else if (i_inc) begin
			cnt_d = cnt_q + W'(1); // RULE_24
		end else begin
			cnt_d = cnt_q;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0; // RULE_15
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign o_count = cnt_q;
endmodule : nfc_stat_ctr
`default_nettype wire

// *** nfc_fifo.sv ***
`default_nettype none
module nfc_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_n,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0]   cnt_q, cnt_d;
	logic          push, pop;

	// Full and empty come from the occupancy count, so no slot is wasted.
	assign o_in_ready  = (cnt_q != (AW+1)'(D));
	assign o_out_valid = (cnt_q != '0);
	assign o_out_data  = mem[rd_q];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_d = (wr_q == AW'(D-1)) ? '0 : wr_q + AW'(1);
		end
		if (pop) begin
			rd_d = (rd_q == AW'(D-1)) ? '0 : rd_q + AW'(1);
		end
		if (push && !pop) begin
			cnt_d = cnt_q + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - (AW+1)'(1);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage carries no reset; only the pointers matter.
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_q] <= i_in_data;
		end
	end
endmodule : nfc_fifo
`default_nettype wire

// *** nfc_cmd_checker.sv ***
`default_nettype none
// ------------------------------------------------
// Command block checker
// ------------------------------------------------
module nfc_cmd_checker (
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic        i_cmd_valid,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic        i_online,
	input  wire logic        i_stat_rd,
	input  wire logic        o_cmd_busy,
	input  wire logic        o_cmd_done,
	input  wire logic [7:0]  o_cmd_status,
	input  wire logic        o_accept_all_mc,
	input  wire logic        o_tx_start,
	input  wire logic        o_tx_bad_crc,
	input  wire logic [7:0]  o_stat_byte,
	input  wire logic        o_status_byte_waiting,
	input  wire logic        o_status_block_pending_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tk;
	// A command only counts when the block is idle.
	assign tk = i_cmd_valid && !o_cmd_busy;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	a_allmc_set: assert property (tk && i_cmd_code == 8'h10 |=> o_cmd_done && o_accept_all_mc)
		else $error("accept all set wrong");
	a_allmc_clr: assert property (tk && i_cmd_code == 8'h11 |=> o_cmd_done && !o_accept_all_mc)
		else $error("accept all clear wrong");
	a_mode_init: assert property (tk && (i_cmd_code == 8'h3F || i_cmd_code == 8'h0A) |=> !o_accept_all_mc)
		else $error("mode not restored");
	a_lb_offline: assert property (tk && i_cmd_code == 8'h12 && !i_online |=> o_cmd_done && o_cmd_status == 8'h03)
		else $error("offline loop status wrong");
	a_lb_first: assert property (tk && i_cmd_code == 8'h12 && i_online |=> o_tx_start && o_tx_bad_crc)
		else $error("first test frame wrong");
	a_stats_open: assert property (tk && i_cmd_code == 8'h18 |=> !o_status_block_pending_n && o_cmd_busy)
		else $error("block pending not raised");
	a_byte_hold: assert property (o_status_byte_waiting && !i_stat_rd |=> o_status_byte_waiting && $stable(o_stat_byte))
		else $error("status byte lost");
	a_block_end: assert property ($rose(o_status_block_pending_n) |-> o_cmd_done && o_cmd_status == 8'h00)
		else $error("block end without done");
endmodule : nfc_cmd_checker
`default_nettype wire

// *** nfc_xcvr_model.sv ***
`default_nettype none
// ------------------------------------------------
// Transceiver stand-in
// ------------------------------------------------
module nfc_xcvr_model (
	input  wire logic       i_clk_sys,
	input  wire logic       o_tx_start,
	input  wire logic       o_tx_bad_crc,
	input  wire logic [2:0] lb_mode,
	input  wire logic       hb_on,
	output logic            i_tx_done,
	output logic            i_tx_collided,
	output logic            i_tx_jabber,
	output logic            i_tx_excess,
	output logic            i_rx_done,
	output logic            i_rx_crc_ok,
	output logic            i_rx_data_ok,
	output logic            i_heartbeat
);
	timeunit 1ns;
	timeprecision 1ps;
	logic bad;
	initial {i_tx_done, i_tx_collided, i_tx_jabber, i_tx_excess, i_rx_done, i_rx_crc_ok, i_rx_data_ok, i_heartbeat} = '0;
	// One frame per start; stale flags are inverted.
	always begin
		@(posedge i_clk_sys);
		if (o_tx_start) begin
			bad = o_tx_bad_crc;
			repeat (4) @(posedge i_clk_sys);
			#2;
			i_tx_done = 1;
			{i_tx_collided, i_tx_jabber, i_tx_excess} = {lb_mode == 1, lb_mode == 2, lb_mode == 3};
			@(posedge i_clk_sys);
			#2;
			i_tx_done = 0;
			{i_tx_collided, i_tx_jabber, i_tx_excess} = ~{i_tx_collided, i_tx_jabber, i_tx_excess};
			if (hb_on) begin
				repeat (39) @(posedge i_clk_sys);
				#2 i_heartbeat = 1;
				@(posedge i_clk_sys);
				#2 i_heartbeat = 0;
			end else if (lb_mode < 2 || lb_mode > 3) begin
				repeat (3) @(posedge i_clk_sys);
				#2 i_rx_done = 1;
				i_rx_crc_ok = bad ? lb_mode == 4 : lb_mode != 6;
				i_rx_data_ok = lb_mode != 5;
				@(posedge i_clk_sys);
				#2 i_rx_done = 0;
				{i_rx_crc_ok, i_rx_data_ok} = ~{i_rx_crc_ok, i_rx_data_ok};
			end
		end
	end
endmodule : nfc_xcvr_model
`default_nettype wire

// *** tb.sv ***
`default_nettype none
`define CHK(nm, ex, ac) begin num_checks++; if ((ac) !== (ex)) begin error_cnt++; \
	$display("Error %s exp %h got %h", nm, ex, ac); end end
`define WT(c) begin int k; for (k = 0; k < 4000 && !(c); k++) tick(); \
	if (!(c)) begin error_cnt++; $display("Error wait"); final_report(); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [63:0] MID = 64'h1122334455667788; // Arbitrary value.
	localparam logic [63:0] FID = 64'h99AABBCCDDEEFF01; // Arbitrary value.
	logic i_clk_sys = 0, i_arst_n = 0, i_cmd_valid = 0, i_stat_rd = 0, ev = 0, hb_on = 0;
	logic i_sba_int_en = 0, i_srf_int_en = 0, i_online = 0, i_grp_wr = 0, i_mc_check = 0;
	logic o_cmd_busy, o_cmd_done, o_status_byte_waiting, o_status_block_pending_n, o_host_int;
	logic o_tx_start, o_tx_bad_crc, o_accept_all_mc, o_mc_busy, o_mc_done, o_mc_accept;
	logic [7:0]  o_cmd_status, o_stat_byte, i_cmd_code = 0;
	logic [47:0] o_tx_addr, i_grp_addr = 0, i_mc_dest = 0, i_phys_addr = 48'h0A1B2C3D4E5F;
	logic [15:0] i_rx_fifo_frames = 16'h0005;
	logic [5:0]  i_grp_idx = 0;
	logic [2:0]  lb_mode = 0;
	wire logic i_tx_done, i_tx_collided, i_tx_jabber, i_tx_excess, i_rx_done, i_rx_crc_ok, i_rx_data_ok, i_heartbeat;
	// One strobe feeds every counter event.
	wire logic i_ev_rx_frame = ev, i_ev_tx_frame = ev, i_ev_excess = ev, i_ev_runt = ev, i_ev_lost = ev;
	wire logic i_ev_mc_acc = ev, i_ev_mc_rej = ev, i_ev_crc_err = ev, i_ev_align_err = ev;
	wire logic i_ev_coll = ev, i_ev_late_coll = ev;
	int error_cnt = 0, num_checks = 0;
	nfc_cmd_top #(.MODULE_ID(MID), .FW_ID(FID)) i_dut (.*);
	nfc_xcvr_model i_xcvr (.*);
	always #12.5 i_clk_sys = ~i_clk_sys;
	task automatic tick(int n = 1);
		repeat (n) @(posedge i_clk_sys);
		#2;
	endtask : tick
	task final_report;
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic cmd(logic [7:0] c, logic [7:0] st);
		tick();
		i_cmd_code = c;
		i_cmd_valid = 1;
		tick();
		i_cmd_valid = 0;
		if (c == 8'h18) return;
		`WT(o_cmd_done)
		`CHK("status", st, o_cmd_status)
	endtask : cmd
	task automatic mc(logic [47:0] a, logic ex);
		tick();
		i_mc_dest = a;
		i_mc_check = 1;
		tick();
		i_mc_check = 0;
		`WT(o_mc_done)
		`CHK("mc accept", ex, o_mc_accept)
	endtask : mc
	task automatic gw(logic [5:0] ix, logic [47:0] a);
		i_grp_idx = ix;
		i_grp_addr = a;
		i_grp_wr = 1;
		tick();
		i_grp_wr = 0;
		tick();
	endtask : gw
	task automatic t_mode;
		cmd(8'h10, 8'h00);
		`CHK("allmc", 1'b1, o_accept_all_mc)
		cmd(8'h11, 8'h00);
		`CHK("allmc", 1'b0, o_accept_all_mc)
		cmd(8'h10, 8'h00);
		cmd(8'h3F, 8'h00);
		`CHK("allmc", 1'b0, o_accept_all_mc)
		cmd(8'h10, 8'h00);
		cmd(8'h0A, 8'h00);
		`CHK("allmc", 1'b0, o_accept_all_mc)
	endtask : t_mode
	task automatic t_mc;
		gw(6'h05, 48'h01005E000001);
		gw(6'h3E, 48'h0300AB00CD07);
		mc(48'h01005E000001, 1'b1);
		mc(48'h0300AB00CD07, 1'b1);
		mc(48'h01005E000002, 1'b0);
		cmd(8'h10, 8'h00);
		mc(48'h01005E000002, 1'b1);
		cmd(8'h11, 8'h00);
	endtask : t_mc
	task automatic t_lb;
		logic [7:0] ex [7] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0C, 8'h0D, 8'h0E};
		cmd(8'h12, 8'h03);
		`CHK("tx addr", 48'h020701000000, o_tx_addr)
		i_online = 1;
		for (int m = 0; m < 7; m++) begin
			lb_mode = 3'(m);
			cmd(8'h12, ex[m]);
		end
		lb_mode = 0;
		hb_on = 1;
		cmd(8'h13, 8'h00);
		hb_on = 0;
		cmd(8'h13, 8'h0B);
	endtask : t_lb
	// Counters hold n events unless just cleared.
	task automatic t_stats(int n, bit rst);
		logic [7:0] b [64];
		b = '{default: 8'h00};
		b[0] = 8'h3E;
		for (int i = 0; i < 6; i++) b[2+i] = i_phys_addr[47-8*i -: 8];
		for (int i = 0; i < 12; i++) {b[9+2*i], b[8+2*i]} = (i == 1) ? i_rx_fifo_frames : 16'(rst ? 0 : n);
		for (int i = 0; i < 8; i++) {b[48+i], b[56+i]} = {MID[63-8*i -: 8], FID[63-8*i -: 8]};
		repeat (n) begin
			ev = 1;
			tick();
			ev = 0;
			tick();
		end
		if (rst) cmd(8'h3F, 8'h00);
		i_srf_int_en = 1;
		cmd(8'h18, 8'h00);
		`CHK("pend", 1'b0, o_status_block_pending_n)
		for (int i = 0; i < 64; i++) begin
			`WT(o_status_byte_waiting)
			if (i == 1) `CHK("int", 1'b1, o_host_int)
			`CHK("block byte", b[i], o_stat_byte)
			i_stat_rd = 1;
			tick();
			i_stat_rd = 0;
			tick();
		end
		`WT(o_status_block_pending_n)
		`CHK("end status", 8'h00, o_cmd_status)
	endtask : t_stats
	initial begin
		tick(6);
		i_arst_n = 1;
		tick(3);
		t_mode();
		t_mc();
		t_lb();
		t_stats(2, 0);
		t_stats(0, 0);
		t_stats(3, 1);
		final_report();
	end
endmodule : tb
bind nfc_cmd_top nfc_cmd_checker i_chk (.*);
`default_nettype wire
